// ### rtl/pad_mux_map.svh
`ifndef PAD_MUX_MAP_SVH
`define PAD_MUX_MAP_SVH
// How it works
// (R1) test, clock, reset pins ignore all software
// (R2) other pads follow programmed select registers
// (R3) gpio and analog pads undriven through reset
// (R4) test port enable: pull-down input, undriven
// (R5) tdi/tms pull-up inputs; tdo undriven at reset
// (R6) A2: gpio, timer ch1, serial out
// (R7) A2 feeds timer ch1 input, irq source 1
// (R8) A3: gpio, timer ch2, pwm a3
// (R9) boot mode 0 from A3 at default
// (R10) serial clock input from A1 or A11
// (R11) A11: gpio, serial clock, pwm a0, a2
// (R12) A12: gpio, serial out, pwm a2, b2
// (R13) code 0011 routes pad to sent rx1
// (R14) B7..B14 input only, only code 0000
// (R15) code 0010 routes B7 to lin0 rx
// (R16) code 0001 routes B13 to lin1 rx
// (R17) H8: pwm2 a1, chip select 6, mii rxd2
// (R18) H10: pwm2 aux 2, timer2 ch2
// (R19) H11: pwm2 a2 and its input
// (R20) input select default leaves every input but boot mode 0 disconnected
// (R21) reserved code: no function, driver off

`define SEL_W 4
`define ADDR_W 12
`define DATA_W 32
`define N_BIDIR 7
`define N_GPI 8
`define N_PFS 15
`define N_ISS 10
`define N_FN 15

`define SEL_DEF 4'h0
`define SEL_ALT1 4'h1
`define SEL_ALT2 4'h2
`define SEL_ALT3 4'h3

`define REG_STRIDE 4
`define PFS_BASE 12'h000
`define ISS_BASE 12'h400
`define STAT_ADDR 12'h800
`define PFS_ADDR(n) (`PFS_BASE + 12'((n) * `REG_STRIDE))
`define ISS_ADDR(n) (`ISS_BASE + 12'((n) * `REG_STRIDE))

`define STAT_OE_LSB 0
`define STAT_IN_LSB 8
`define STAT_GPI_LSB 16

`define PFS_NUM_A2 1
`define PFS_NUM_A3 2
`define PFS_NUM_A11 11
`define PFS_NUM_A12 12
`define PFS_NUM_B7 23
`define PFS_NUM_B14 30
`define PFS_NUM_H8 120
`define PFS_NUM_H10 122
`define PFS_NUM_H11 123

`define PAD_A2 0
`define PAD_A3 1
`define PAD_A11 2
`define PAD_A12 3
`define PAD_H8 4
`define PAD_H10 5
`define PAD_H11 6
`define PFS_GPI_SLOT0 7
`define GPI_B7 0
`define GPI_B13 6

`define ISS_NUM_SCK 48
`define ISS_NUM_TC1 60
`define ISS_NUM_IRQ1 174
`define ISS_NUM_BOOT0 169
`define ISS_NUM_SENT1 214
`define ISS_NUM_LIN0 165
`define ISS_NUM_LIN1 166
`define ISS_NUM_MII2 228
`define ISS_NUM_T2C2 73
`define ISS_NUM_PWM2A2 112

`define ISS_SCK 0
`define ISS_TC1 1
`define ISS_IRQ1 2
`define ISS_BOOT0 3
`define ISS_SENT1 4
`define ISS_LIN0 5
`define ISS_LIN1 6
`define ISS_MII2 7
`define ISS_T2C2 8
`define ISS_PWM2A2 9

`define PULL_ON 1'b1
`define DRIVE_OFF 1'b0
`define WAIT_IDLE 1'b1
`endif

// ### rtl/pad_mux_pkg.sv
`default_nettype none
`include "pad_mux_map.svh"
package pad_mux_pkg;
  typedef logic [`SEL_W-1:0] sel_t;

  typedef enum logic [3:0] {
    FN_NONE,
    FN_GPIO,
    FN_TIMER_CHANNEL_1,
    FN_SERIAL_DATA_OUT,
    FN_TIMER_CHANNEL_2,
    FN_PWM_CHANNEL_A3,
    FN_SERIAL_CLOCK,
    FN_PWM_CHANNEL_A0,
    FN_PWM_CHANNEL_A2,
    FN_PWM_CHANNEL_B2,
    FN_PWM2_CHANNEL_A1,
    FN_CHIP_SELECT_6,
    FN_PWM_AUX_CHANNEL_2,
    FN_TIMER2_CHANNEL_2,
    FN_PWM2_CHANNEL_A2
  } fn_t;

  typedef struct packed {
    logic [`N_PFS-1:0][`SEL_W-1:0] pfs;
    logic [`N_ISS-1:0][`SEL_W-1:0] iss;
    logic waitrequest;
    logic [`DATA_W-1:0] rdata;
    logic [`N_BIDIR-1:0] pad_do;
    logic [`N_BIDIR-1:0] pad_oe;
    logic [`N_BIDIR-1:0] gpio_di;
    logic [`N_GPI-1:0] gpi_di;
    logic [`N_ISS-1:0] periph_in;
    logic tdo_do;
    logic tdo_oe;
    logic trst_pd;
    logic tdi_pu;
    logic tms_pu;
  } state_t;
endpackage : pad_mux_pkg
`default_nettype wire

// ### rtl/pad_drive_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "pad_mux_map.svh"
interface pad_drive_if;
  logic [`N_BIDIR-1:0][`SEL_W-1:0] sel;
  logic [`N_BIDIR-1:0] gpio_do;
  logic [`N_BIDIR-1:0] gpio_oe;
  logic [`N_FN-1:0] fn_do;
  logic [`N_FN-1:0] fn_oe;
  logic [`N_BIDIR-1:0] pad_do;
  logic [`N_BIDIR-1:0] pad_oe;
  modport core (output sel, gpio_do, gpio_oe, fn_do, fn_oe, input pad_do, pad_oe);
  modport mux (input sel, gpio_do, gpio_oe, fn_do, fn_oe, output pad_do, pad_oe);
endinterface : pad_drive_if
`default_nettype wire

// ### rtl/pad_out_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "pad_mux_map.svh"
module pad_out_mux
  import pad_mux_pkg::*;
(
  pad_drive_if.mux drv // selects in, pad drive out
);
  // output function chosen by a pad and its select code
  function automatic fn_t out_fn(input int unsigned pad, input sel_t s);
    out_fn = FN_NONE; // [R21]
    if (s == `SEL_DEF) begin
      out_fn = FN_GPIO; // [R2]
    end else begin
      case (pad)
        `PAD_A2: begin
          if (s == `SEL_ALT1) out_fn = FN_TIMER_CHANNEL_1; // [R6]
          if (s == `SEL_ALT2) out_fn = FN_SERIAL_DATA_OUT; // [R6]
        end
        `PAD_A3: begin
          if (s == `SEL_ALT1) out_fn = FN_TIMER_CHANNEL_2; // [R8]
          if (s == `SEL_ALT3) out_fn = FN_PWM_CHANNEL_A3; // [R8]
        end
        `PAD_A11: begin
          if (s == `SEL_ALT1) out_fn = FN_SERIAL_CLOCK; // [R11]
          if (s == `SEL_ALT2) out_fn = FN_PWM_CHANNEL_A0; // [R11]
          if (s == `SEL_ALT3) out_fn = FN_PWM_CHANNEL_A2; // [R11]
        end
        `PAD_A12: begin
          if (s == `SEL_ALT1) out_fn = FN_SERIAL_DATA_OUT; // [R12]
          if (s == `SEL_ALT2) out_fn = FN_PWM_CHANNEL_A2; // [R12]
          if (s == `SEL_ALT3) out_fn = FN_PWM_CHANNEL_B2; // [R12]
        end
        `PAD_H8: begin
          if (s == `SEL_ALT1) out_fn = FN_PWM2_CHANNEL_A1; // [R17]
          if (s == `SEL_ALT3) out_fn = FN_CHIP_SELECT_6; // [R17]
        end
        `PAD_H10: begin
          if (s == `SEL_ALT1) out_fn = FN_PWM_AUX_CHANNEL_2; // [R18]
          if (s == `SEL_ALT2) out_fn = FN_TIMER2_CHANNEL_2; // [R18]
        end
        `PAD_H11: begin
          if (s == `SEL_ALT1) out_fn = FN_PWM2_CHANNEL_A2; // [R19]
        end
        default: out_fn = FN_NONE;
      endcase
    end
  endfunction : out_fn

  always_comb begin
    fn_t f;
    f = FN_NONE;
    drv.pad_do = '0;
    drv.pad_oe = '0;
    for (int unsigned p = 0; p < `N_BIDIR; p++) begin
      f = out_fn(p, drv.sel[p]);
      if (f == FN_GPIO) begin
        drv.pad_do[p] = drv.gpio_do[p];
        drv.pad_oe[p] = drv.gpio_oe[p];
      end else if (f != FN_NONE) begin
        drv.pad_do[p] = drv.fn_do[f];
        drv.pad_oe[p] = drv.fn_oe[f];
      end
    end
  end
endmodule : pad_out_mux
`default_nettype wire

// ### rtl/pad_function_input_mux.sv
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pad_mux_map.svh"
module pad_function_input_mux
  import pad_mux_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [`ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [`DATA_W-1:0] avs_writedata, // write data
  output logic [`DATA_W-1:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall, high by default
  input wire logic [`N_BIDIR-1:0] pad_in, // A2,A3,A11,A12,H8,H10,H11 levels
  output logic [`N_BIDIR-1:0] pad_out, // pad drive value
  output logic [`N_BIDIR-1:0] pad_oe, // pad drive enable
  input wire logic [`N_GPI-1:0] gpi_pad_in, // B7..B14 levels
  input wire logic a1_pad_in, // A1 level
  input wire logic sent_pad_in, // level of pad feeding sent rx1
  input wire logic [`N_BIDIR-1:0] gpio_do, // gpio drive value
  input wire logic [`N_BIDIR-1:0] gpio_oe, // gpio drive enable
  output logic [`N_BIDIR-1:0] gpio_di, // gpio input value
  output logic [`N_GPI-1:0] general_input_only_di, // B7..B14 value
  input wire logic [`N_FN-1:0] fn_do, // peripheral drive, by fn_t
  input wire logic [`N_FN-1:0] fn_oe, // peripheral enable, by fn_t
  output logic serial_clock_in, // serial port 2 clock input
  output logic timer_channel_1_in, // timer channel 1 input
  output logic ext_irq_source_1, // external interrupt source 1
  output logic boot_mode_pin_0, // boot mode input 0
  output logic sent_rx1_in, // sent receiver channel 1
  output logic lin0_rxd, // first lin receive
  output logic lin1_rxd, // second lin receive
  output logic mii_rxd2, // mii receive data 2
  output logic timer2_channel_2_in, // timer 2 channel 2 input
  output logic pwm2_channel_a2_in, // second pwm channel a2 input
  input wire logic tap_tdo, // tap serial out value
  input wire logic tap_tdo_en, // tap shifting
  output logic tdo_out, // tdo pad value
  output logic tdo_oe, // tdo pad enable
  output logic test_port_enable_pin_pull_down, // trst weak pull-down
  output logic tdi_pull_up, // tdi weak pull-up
  output logic tms_pull_up // tms weak pull-up
);
  state_t s_q;
  state_t s_d;
  pad_drive_if drv ();

  // pad function select slot, {valid, slot}
  function automatic logic [4:0] pfs_decode(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] off;
    off = a - `PFS_ADDR(`PFS_NUM_B7);
    pfs_decode = 5'h00;
    case (a)
      `PFS_ADDR(`PFS_NUM_A2): pfs_decode = {1'b1, 4'(`PAD_A2)};
      `PFS_ADDR(`PFS_NUM_A3): pfs_decode = {1'b1, 4'(`PAD_A3)};
      `PFS_ADDR(`PFS_NUM_A11): pfs_decode = {1'b1, 4'(`PAD_A11)};
      `PFS_ADDR(`PFS_NUM_A12): pfs_decode = {1'b1, 4'(`PAD_A12)};
      `PFS_ADDR(`PFS_NUM_H8): pfs_decode = {1'b1, 4'(`PAD_H8)};
      `PFS_ADDR(`PFS_NUM_H10): pfs_decode = {1'b1, 4'(`PAD_H10)};
      `PFS_ADDR(`PFS_NUM_H11): pfs_decode = {1'b1, 4'(`PAD_H11)};
      default: begin
        if (a >= `PFS_ADDR(`PFS_NUM_B7) && a <= `PFS_ADDR(`PFS_NUM_B14) &&
            off[1:0] == 2'h0) begin
          pfs_decode = {1'b1, 4'(`PFS_GPI_SLOT0) + off[5:2]};
        end
      end
    endcase
  endfunction : pfs_decode

  // input source select slot, {valid, slot}
  function automatic logic [4:0] iss_decode(input logic [`ADDR_W-1:0] a);
    iss_decode = 5'h00;
    case (a)
      `ISS_ADDR(`ISS_NUM_SCK): iss_decode = {1'b1, 4'(`ISS_SCK)};
      `ISS_ADDR(`ISS_NUM_TC1): iss_decode = {1'b1, 4'(`ISS_TC1)};
      `ISS_ADDR(`ISS_NUM_IRQ1): iss_decode = {1'b1, 4'(`ISS_IRQ1)};
      `ISS_ADDR(`ISS_NUM_BOOT0): iss_decode = {1'b1, 4'(`ISS_BOOT0)};
      `ISS_ADDR(`ISS_NUM_SENT1): iss_decode = {1'b1, 4'(`ISS_SENT1)};
      `ISS_ADDR(`ISS_NUM_LIN0): iss_decode = {1'b1, 4'(`ISS_LIN0)};
      `ISS_ADDR(`ISS_NUM_LIN1): iss_decode = {1'b1, 4'(`ISS_LIN1)};
      `ISS_ADDR(`ISS_NUM_MII2): iss_decode = {1'b1, 4'(`ISS_MII2)};
      `ISS_ADDR(`ISS_NUM_T2C2): iss_decode = {1'b1, 4'(`ISS_T2C2)};
      `ISS_ADDR(`ISS_NUM_PWM2A2): iss_decode = {1'b1, 4'(`ISS_PWM2A2)};
      default: iss_decode = 5'h00;
    endcase
  endfunction : iss_decode

  // source passes only when its select code is programmed
  function automatic logic pick(input sel_t s, input sel_t code, input logic src);
    pick = (s == code) & src;
  endfunction : pick

  function automatic logic [`DATA_W-1:0] read_val(input logic [`ADDR_W-1:0] a,
                                                  input state_t s);
    logic [4:0] pd;
    logic [4:0] id;
    pd = pfs_decode(a);
    id = iss_decode(a);
    read_val = '0;
    if (pd[4]) begin
      read_val = `DATA_W'(s.pfs[pd[3:0]]);
    end else if (id[4]) begin
      read_val = `DATA_W'(s.iss[id[3:0]]);
    end else if (a == `STAT_ADDR) begin
      read_val = (`DATA_W'(s.pad_oe) << `STAT_OE_LSB) |
                 (`DATA_W'(s.gpio_di) << `STAT_IN_LSB) |
                 (`DATA_W'(s.gpi_di) << `STAT_GPI_LSB);
    end
  endfunction : read_val

  assign drv.gpio_do = gpio_do;
  assign drv.gpio_oe = gpio_oe;
  assign drv.fn_do = fn_do;
  assign drv.fn_oe = fn_oe;

  always_comb begin
    for (int unsigned p = 0; p < `N_BIDIR; p++) begin
      drv.sel[p] = s_q.pfs[p];
    end
  end

  pad_out_mux u_out_mux (
    .drv(drv.mux)
  );

  always_comb begin
    logic [4:0] pd;
    logic [4:0] id;
    logic [`N_ISS-1:0] pin;
    pd = pfs_decode(avs_address);
    id = iss_decode(avs_address);
    pin = '0;
    s_d = s_q;

    // bus: one wait cycle, then the access completes
    if ((avs_read || avs_write) && s_q.waitrequest) begin
      s_d.waitrequest = 1'b0;
      s_d.rdata = avs_read ? read_val(avs_address, s_q) : '0;
    end else if (avs_read || avs_write) begin
      s_d.waitrequest = `WAIT_IDLE;
      if (avs_write && pd[4]) begin
        s_d.pfs[pd[3:0]] = avs_writedata[`SEL_W-1:0]; // [R2]
      end
      if (avs_write && id[4]) begin
        s_d.iss[id[3:0]] = avs_writedata[`SEL_W-1:0]; // [R2]
      end
    end else begin
      s_d.waitrequest = `WAIT_IDLE;
    end

    // pad drive, reserved codes leave the driver off
    s_d.pad_do = drv.pad_do; // [R21]
    s_d.pad_oe = drv.pad_oe; // [R2] [R3]
    s_d.gpio_di = pad_in;

    // input-only pads carry gpi only at code 0000
    for (int unsigned g = 0; g < `N_GPI; g++) begin
      s_d.gpi_di[g] = pick(s_q.pfs[`PFS_GPI_SLOT0 + g], `SEL_DEF, gpi_pad_in[g]); // [R14]
    end

    // peripheral inputs; unmatched codes give 0
    pin[`ISS_SCK] = pick(s_q.iss[`ISS_SCK], `SEL_ALT1, a1_pad_in) |
                    pick(s_q.iss[`ISS_SCK], `SEL_ALT2, pad_in[`PAD_A11]); // [R10]
    pin[`ISS_TC1] = pick(s_q.iss[`ISS_TC1], `SEL_ALT2, pad_in[`PAD_A2]); // [R7]
    pin[`ISS_IRQ1] = pick(s_q.iss[`ISS_IRQ1], `SEL_ALT1, pad_in[`PAD_A2]); // [R7]
    pin[`ISS_BOOT0] = pick(s_q.iss[`ISS_BOOT0], `SEL_DEF, pad_in[`PAD_A3]); // [R9]
    pin[`ISS_SENT1] = pick(s_q.iss[`ISS_SENT1], `SEL_ALT3, sent_pad_in); // [R13]
    pin[`ISS_LIN0] = pick(s_q.iss[`ISS_LIN0], `SEL_ALT2,
                          gpi_pad_in[`GPI_B7]); // [R15]
    pin[`ISS_LIN1] = pick(s_q.iss[`ISS_LIN1], `SEL_ALT1,
                          gpi_pad_in[`GPI_B13]); // [R16]
    pin[`ISS_MII2] = pick(s_q.iss[`ISS_MII2], `SEL_ALT1, pad_in[`PAD_H8]); // [R17]
    pin[`ISS_T2C2] = pick(s_q.iss[`ISS_T2C2], `SEL_ALT2, pad_in[`PAD_H10]); // [R18]
    pin[`ISS_PWM2A2] = pick(s_q.iss[`ISS_PWM2A2], `SEL_ALT2,
                            pad_in[`PAD_H11]); // [R19]
    s_d.periph_in = pin; // [R20]

    // test pins: no register reaches these
    s_d.trst_pd = `PULL_ON; // [R1] [R4]
    s_d.tdi_pu = `PULL_ON; // [R1] [R5]
    s_d.tms_pu = `PULL_ON; // [R1] [R5]
    s_d.tdo_do = tap_tdo;
    s_d.tdo_oe = tap_tdo_en; // [R5]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0; // [R3] [R20]
      s_q.waitrequest <= `WAIT_IDLE;
      s_q.trst_pd <= `PULL_ON; // [R4]
      s_q.tdi_pu <= `PULL_ON; // [R5]
      s_q.tms_pu <= `PULL_ON; // [R5]
      s_q.tdo_oe <= `DRIVE_OFF; // [R5]
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitrequest;
  assign pad_out = s_q.pad_do;
  assign pad_oe = s_q.pad_oe;
  assign gpio_di = s_q.gpio_di;
  assign general_input_only_di = s_q.gpi_di;
  assign serial_clock_in = s_q.periph_in[`ISS_SCK];
  assign timer_channel_1_in = s_q.periph_in[`ISS_TC1];
  assign ext_irq_source_1 = s_q.periph_in[`ISS_IRQ1];
  assign boot_mode_pin_0 = s_q.periph_in[`ISS_BOOT0];
  assign sent_rx1_in = s_q.periph_in[`ISS_SENT1];
  assign lin0_rxd = s_q.periph_in[`ISS_LIN0];
  assign lin1_rxd = s_q.periph_in[`ISS_LIN1];
  assign mii_rxd2 = s_q.periph_in[`ISS_MII2];
  assign timer2_channel_2_in = s_q.periph_in[`ISS_T2C2];
  assign pwm2_channel_a2_in = s_q.periph_in[`ISS_PWM2A2];
  assign tdo_out = s_q.tdo_do;
  assign tdo_oe = s_q.tdo_oe;
  assign test_port_enable_pin_pull_down = s_q.trst_pd;
  assign tdi_pull_up = s_q.tdi_pu;
  assign tms_pull_up = s_q.tms_pu;
endmodule : pad_function_input_mux
`default_nettype wire

// ### dv/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pad_mux_map.svh"
module periph_model
  import pad_mux_pkg::*;
(
  input wire logic en, // all peripherals drive their pads
  output logic [`N_FN-1:0] fn_do, // peripheral drive, by fn_t
  output logic [`N_FN-1:0] fn_oe, // peripheral enable, by fn_t
  output logic [`N_BIDIR-1:0] gpio_do, // gpio drive value
  output logic [`N_BIDIR-1:0] gpio_oe, // gpio drive enable
  output logic tap_tdo, // tap serial out
  output logic tap_tdo_en // tap shifting
);
  // alternating levels so neighbouring functions of one pad differ
  assign fn_do = 15'h5555;
  assign fn_oe = {`N_FN{en}};
  assign gpio_do = 7'h2A;
  assign gpio_oe = {`N_BIDIR{en}};
  assign tap_tdo = 1'b1;
  assign tap_tdo_en = en;
endmodule : periph_model
`default_nettype wire

// ### dv/pfim_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "pad_mux_map.svh"
module pfim_asserts
  import pad_mux_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [`DATA_W-1:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic [`N_BIDIR-1:0] pad_in, // pad levels
  input wire logic [`N_BIDIR-1:0] pad_oe, // pad enables
  input wire logic [`N_BIDIR-1:0] gpio_oe, // gpio enables
  input wire logic [`N_FN-1:0] fn_oe, // peripheral enables
  input wire logic [`N_BIDIR-1:0] gpio_di, // gpio inputs
  input wire logic [`N_GPI-1:0] gpi_pad_in, // input-only pads
  input wire logic [`N_GPI-1:0] general_input_only_di, // their values
  input wire logic tap_tdo_en, // tap shifting
  input wire logic tdo_oe, // tdo enable
  input wire logic test_port_enable_pin_pull_down, // pull-down
  input wire logic tdi_pull_up, // pull-up
  input wire logic tms_pull_up // pull-up
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_wait_answer: assert property (req_taken |=> one_answer)
    else $error("bus request not answered after one wait cycle");
  chk_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  chk_rdata_upper: assert property (!avs_waitrequest |-> avs_readdata[31:24] == 8'h00)
    else $error("read data upper byte not zero");
  chk_pulls_fixed: assert property (
    test_port_enable_pin_pull_down && tdi_pull_up && tms_pull_up)
    else $error("test pin pull dropped");
  chk_reset_hiz: assert property ($rose(rst_n) |-> pad_oe == 7'h00 && !tdo_oe)
    else $error("pad driven right after reset");
  chk_tdo_follow: assert property ($past(rst_n) |-> tdo_oe == $past(tap_tdo_en))
    else $error("tdo enable not following tap");
  chk_gpio_follow: assert property ($past(rst_n) |-> gpio_di == $past(pad_in))
    else $error("gpio input not one cycle behind pad");
  chk_oe_cause: assert property (
    pad_oe[0] |-> $past(gpio_oe[0]) || $past(fn_oe[2]) || $past(fn_oe[3]))
    else $error("pad a2 driven without a source");
  chk_gpi_gate: assert property ((general_input_only_di & ~$past(gpi_pad_in)) == 8'h00)
    else $error("input-only value without pad level");
endmodule : pfim_asserts
bind pad_function_input_mux pfim_asserts pfim_asserts_i (.clk, .rst_n, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .pad_in, .pad_oe, .gpio_oe, .fn_oe, .gpio_di, .gpi_pad_in,
  .general_input_only_di, .tap_tdo_en, .tdo_oe, .test_port_enable_pin_pull_down, .tdi_pull_up,
  .tms_pull_up);
`default_nettype wire

// ### dv/pad_function_input_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pad_mux_map.svh"
module pad_function_input_mux_tb_top;
  import pad_mux_pkg::*;
  typedef struct {int num; int pad; logic [3:0] sel; fn_t fn;} orow_t;
  typedef struct {int num; int idx; logic [3:0] code; int src; logic hit;} irow_t;
  orow_t orows[25] = '{'{1, 0, 4'h0, FN_GPIO}, '{1, 0, 4'h1, FN_TIMER_CHANNEL_1},
    '{1, 0, 4'h2, FN_SERIAL_DATA_OUT}, '{1, 0, 4'h3, FN_NONE}, '{1, 0, 4'hF, FN_NONE},
    '{2, 1, 4'h1, FN_TIMER_CHANNEL_2}, '{2, 1, 4'h2, FN_NONE}, '{2, 1, 4'h3, FN_PWM_CHANNEL_A3},
    '{2, 1, 4'h4, FN_NONE}, '{11, 2, 4'h1, FN_SERIAL_CLOCK}, '{11, 2, 4'h2, FN_PWM_CHANNEL_A0},
    '{11, 2, 4'h3, FN_PWM_CHANNEL_A2}, '{11, 2, 4'h4, FN_NONE},
    '{12, 3, 4'h1, FN_SERIAL_DATA_OUT}, '{12, 3, 4'h2, FN_PWM_CHANNEL_A2},
    '{12, 3, 4'h3, FN_PWM_CHANNEL_B2}, '{12, 3, 4'h4, FN_NONE},
    '{120, 4, 4'h1, FN_PWM2_CHANNEL_A1}, '{120, 4, 4'h2, FN_NONE},
    '{120, 4, 4'h3, FN_CHIP_SELECT_6}, '{122, 5, 4'h1, FN_PWM_AUX_CHANNEL_2},
    '{122, 5, 4'h2, FN_TIMER2_CHANNEL_2},
    '{122, 5, 4'h3, FN_NONE}, '{123, 6, 4'h1, FN_PWM2_CHANNEL_A2}, '{123, 6, 4'h2, FN_NONE}};
  // src: 0..6 bidir pads, 7..14 b7..b14, 15 a1, 16 sent pad
  irow_t irows[15] = '{'{48, 0, 4'h1, 15, 1'b1}, '{48, 0, 4'h2, 2, 1'b1},
    '{48, 0, 4'h3, 2, 1'b0}, '{60, 1, 4'h2, 0, 1'b1}, '{60, 1, 4'h1, 0, 1'b0},
    '{174, 2, 4'h1, 0, 1'b1},
    '{169, 3, 4'h0, 1, 1'b1}, '{169, 3, 4'h1, 1, 1'b0}, '{214, 4, 4'h3, 16, 1'b1},
    '{165, 5, 4'h2, 7, 1'b1}, '{166, 6, 4'h1, 13, 1'b1}, '{166, 6, 4'h0, 13, 1'b0},
    '{228, 7, 4'h1, 4, 1'b1}, '{73, 8, 4'h2, 5, 1'b1}, '{112, 9, 4'h2, 6, 1'b1}};
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, en, tap_tdo, tap_tdo_en, tdo_out, tdo_oe;
  logic trst_pd, tdi_pu, tms_pu, sck_i, tc1_i, irq1_i, boot0_i, sent1_i, lin0_i, lin1_i, mii2_i;
  logic t2c2_i, pwm2a2_i;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdq;
  logic [16:0] src_q;
  logic [6:0] pad_out, pad_oe, gpio_do, gpio_oe, gpio_di;
  logic [7:0] gpi_di;
  logic [14:0] fn_do, fn_oe;
  logic [9:0] pin_v;
  int fail_count, cmp_count;
  assign pin_v = {pwm2a2_i, t2c2_i, mii2_i, lin1_i, lin0_i, sent1_i, boot0_i, irq1_i, tc1_i,
    sck_i};
  pad_function_input_mux pad_function_input_mux_i (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pad_in(src_q[6:0]), .pad_out(pad_out), .pad_oe(pad_oe), .gpi_pad_in(src_q[14:7]),
    .a1_pad_in(src_q[15]), .sent_pad_in(src_q[16]), .gpio_do(gpio_do), .gpio_oe(gpio_oe),
    .gpio_di(gpio_di), .general_input_only_di(gpi_di), .fn_do(fn_do), .fn_oe(fn_oe),
    .serial_clock_in(sck_i), .timer_channel_1_in(tc1_i), .ext_irq_source_1(irq1_i),
    .boot_mode_pin_0(boot0_i), .sent_rx1_in(sent1_i), .lin0_rxd(lin0_i), .lin1_rxd(lin1_i),
    .mii_rxd2(mii2_i), .timer2_channel_2_in(t2c2_i), .pwm2_channel_a2_in(pwm2a2_i),
    .tap_tdo(tap_tdo), .tap_tdo_en(tap_tdo_en), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .test_port_enable_pin_pull_down(trst_pd), .tdi_pull_up(tdi_pu), .tms_pull_up(tms_pu));
  periph_model periph_model_i (.en(en), .fn_do(fn_do), .fn_oe(fn_oe), .gpio_do(gpio_do),
    .gpio_oe(gpio_oe), .tap_tdo(tap_tdo), .tap_tdo_en(tap_tdo_en));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // holds the request until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    tick(1);
  endtask : bus
  function automatic logic exp_out(orow_t r);
    if (r.fn == FN_GPIO) return 7'h2A >> r.pad;
    if (r.fn == FN_NONE) return 1'b0;
    return 15'h5555 >> r.fn;
  endfunction : exp_out
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    src_q = 17'h00000;
    en = 1'b1;
    tick(8);
    chk("pad_oe in reset", pad_oe, 7'h00);
    chk("pulls in reset", {trst_pd, tdi_pu, tms_pu}, 3'h7);
    chk("tdo_oe in reset", tdo_oe, 1'b0);
    rst_n <= 1'b1;
    tick(1);
    chk("pad_oe after release", pad_oe, 7'h00);
    $display("test reset done");
    foreach (orows[i]) begin
      bus(1'b0, `PFS_ADDR(orows[i].num), {28'h0, orows[i].sel});
      tick(2);
      chk("pad_oe", pad_oe[orows[i].pad], orows[i].fn != FN_NONE);
      chk("pad_out", pad_out[orows[i].pad], exp_out(orows[i]));
      bus(1'b1, `PFS_ADDR(orows[i].num), 32'h0);
      chk("select readback", rdq, {28'h0, orows[i].sel});
      bus(1'b0, `PFS_ADDR(orows[i].num), 32'h0);
    end
    $display("test output selects done");
    foreach (irows[i]) begin
      bus(1'b0, `ISS_ADDR(irows[i].num), {28'h0, irows[i].code});
      src_q <= 17'h00001 << irows[i].src;
      tick(2);
      chk("peripheral inputs", pin_v,
        irows[i].hit ? 10'h001 << irows[i].idx : 10'h000);
      chk("gpio input", gpio_di, (32'h1 << irows[i].src) & 32'h7F);
      src_q <= 17'h00000;
      bus(1'b0, `ISS_ADDR(irows[i].num), 32'h0);
    end
    $display("test input selects done");
    src_q <= 17'h07F80;
    for (int n = 23; n <= 30; n++) begin
      bus(1'b0, `PFS_ADDR(n), (n % 2) ? 32'h1 : 32'hF);
      tick(2);
      chk("input-only value", gpi_di, 8'hFF & ~(8'h01 << (n - 23)));
      bus(1'b0, `PFS_ADDR(n), 32'h0);
    end
    bus(1'b0, `STAT_ADDR, 32'hFFFFFFFF);
    bus(1'b1, `STAT_ADDR, 32'h0);
    chk("status input-only", rdq[23:16], 8'hFF);
    chk("status drive", rdq[14:0], 15'h007F);
    bus(1'b1, 12'h7FC, 32'h0);
    chk("unmapped read", rdq, 32'h0);
    $display("test input-only pads done");
    en <= 1'b0;
    tick(2);
    chk("tdo_oe idle", tdo_oe, 1'b0);
    en <= 1'b1;
    bus(1'b0, `PFS_ADDR(1), 32'h1);
    rst_n <= 1'b0;
    tick(2);
    chk("pad_oe in second reset", pad_oe, 7'h00);
    rst_n <= 1'b1;
    tick(1);
    chk("pad_oe after second release", pad_oe, 7'h00);
    tick(1);
    chk("gpio default drive", pad_oe, 7'h7F);
    chk("tdo_oe shifting", tdo_oe, 1'b1);
    chk("tdo value", tdo_out, 1'b1);
    bus(1'b1, `PFS_ADDR(1), 32'h0);
    chk("select after reset", rdq, 32'h0);
    chk("pulls at end", {trst_pd, tdi_pu, tms_pu}, 3'h7);
    $display("test second reset done");
    give_verdict();
  end
endmodule : pad_function_input_mux_tb_top
`default_nettype wire
